// file: iwdt_decoder.sv
// Instruction word decoder and instruction cycle sequencer.
// Overview of operation
// RULE1: Each single word is 24 bits; 8-bit opcode selects type, rest are operands.
// RULE2: Five groups: word/byte, bit, literal, signal-processing, control, own layouts.
// RULE3: Double-word instruction spans two words; second word upper 8 bits are zero.
// RULE4: A lone second word executed by itself decodes as a no-operation.
// RULE5: Exactly three opcodes need two words; all others are single word.
// RULE6: Single word takes one cycle; two when condition true or PC changes.
// RULE7: Branches, indirect call/jump, table access and returns take two or three cycles.
// RULE8: Taken skip lasts two cycles, three when the skipped instruction is double word.
// RULE9: Double-word instructions and double-word moves take two cycles.
// RULE10: Working register ops decode base, source with modifier, destination with modifier.
// RULE11: File register ops decode address and destination: same file or register zero.
// RULE12: Bit ops address working or file register; bit from literal or base register.
// RULE13: Literal ALU ops take base and literal; separate destination only when flagged.
// RULE14: Literal moves decode a literal and a working or file register target.
// RULE15: Multiply-accumulate decodes accumulator, multiplicand pair, prefetches and write-back.
// RULE16: Other DSP ops decode accumulator, operand with modifier, shift by register or literal.
// RULE17: Control ops decode a program address, and table ops a table access mode.
// RULE18: Register fields select one of sixteen; register zero is file-op default.
`timescale 1ns/1ps
`include "iwdt_consts.svh"

module iwdt_decoder (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Program memory fetch side.
  input wire logic [`IWDT_WORD_W-1:0] instr_word,
  input wire logic instr_valid,
  output logic fetch_ready,
  // Execution datapath side.
  input wire logic cond_true,
  output iwdt_pkg::iwdt_dec_t dec,
  output logic dec_valid,
  output logic nop_slot,
  output logic [1:0] instr_cycles
);
  import iwdt_pkg::*;

  // ========================================================================
  // State and word holding
  iwdt_state_t state_r, state_nxt;
  logic [`IWDT_WORD_W-1:0] w1_r, w1_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  iwdt_dec_t dec_r, dec_nxt;
  logic dec_valid_r, dec_valid_nxt;
  logic nop_slot_r, nop_slot_nxt;
  logic fetch_ready_r, fetch_ready_nxt;
  logic [1:0] cycles_r, cycles_nxt;
  logic in_word2, take;
  logic [`IWDT_WORD_W-1:0] w1, w2;
  logic [7:0] opc;
  logic [3:0] grp;
  // The first word is held while the second word of a pair is fetched.
  assign in_word2 = (state_r == IWDT_ST_WORD2);
  assign take = instr_valid && fetch_ready_r;
  assign w1 = in_word2 ? w1_r : instr_word;
  assign w2 = in_word2 ? instr_word : '0;
  // RULE1 opcode field
  assign opc = w1[`IWDT_F_OPC];
  assign grp = opc[`IWDT_F_GROUP];

  // ========================================================================
  // Opcode classification and cycle count
  logic is_dw_op, is_skip_op, is_ret_op, is_two_op, is_cond_br, skip_go;
  logic [1:0] cyc_c;
  // RULE5 three two-word opcodes
  assign is_dw_op = (opc == `IWDT_OP_JUMP_ABS) || (opc == `IWDT_OP_CALL_ABS) ||
                    (opc == `IWDT_OP_MOVE_LONG);
  assign is_skip_op = (opc == `IWDT_OP_SKIP_BIT) || (opc == `IWDT_OP_SKIP_CMP);
  assign is_ret_op = (opc == `IWDT_OP_RETURN) || (opc == `IWDT_OP_INT_RETURN);
  // RULE7 fixed two-cycle control
  assign is_two_op = (opc == `IWDT_OP_BRANCH) || (opc == `IWDT_OP_BRANCH_COMP) ||
                     (opc == `IWDT_OP_JUMP_IND) || (opc == `IWDT_OP_CALL_IND) ||
                     (opc == `IWDT_OP_TBL_RD) || (opc == `IWDT_OP_TBL_WR) ||
                     (opc == `IWDT_OP_MOVE_DBL);
  assign is_cond_br = (opc == `IWDT_OP_BRANCH_COND);
  // RULE8 skip taken on true test
  assign skip_go = is_skip_op && cond_true;
  // RULE6 taken condition adds a slot
  // RULE7 returns take three cycles
  assign cyc_c = is_ret_op ? `IWDT_CYC_THREE :
                 (is_two_op || ((is_cond_br || is_skip_op) && cond_true)) ?
                 `IWDT_CYC_TWO : `IWDT_CYC_ONE;

  // ========================================================================
  // Operand field decode
  logic [3:0] wlo_reg, whi_reg;
  iwdt_amode_t wlo_mode, whi_mode;
  iwdt_dec_t dec_c;
  // Low field feeds destinations and single W operands.
  iwdt_wfield #(.LSB(`IWDT_F_WLO_LSB)) u_wlo (.word(w1), .regnum(wlo_reg), .mode(wlo_mode));
  // High field feeds source operands.
  iwdt_wfield #(.LSB(`IWDT_F_WHI_LSB)) u_whi (.word(w1), .regnum(whi_reg), .mode(whi_mode));
  // Sorts the word into a category and unpacks its operand layout.
  always_comb begin
    dec_c = '0;
    dec_c.opcode = opc;
    dec_c.cat = IWDT_CAT_ILLEGAL;
    dec_c.double_word = in_word2;
    dec_c.base_work_reg = w1[`IWDT_F_BASE];
    // RULE2 group dispatch
    case (grp)
      `IWDT_GRP_CTRL: begin
        dec_c.cat = IWDT_CAT_CTRL;
        // RULE17 program address operand
        dec_c.prog_addr = 23'(w1[`IWDT_F_PADDR]);
        case (opc)
          `IWDT_OP_NOP: begin
            // RULE4 lone second word is nop
            dec_c.cat = IWDT_CAT_NOP;
            dec_c.is_nop = 1'b1;
            dec_c.prog_addr = '0;
          end
          `IWDT_OP_JUMP_ABS, `IWDT_OP_CALL_ABS: begin
            // RULE3 address spans both words
            dec_c.prog_addr = {w1[`IWDT_F_DW_ADDR_HI], w2[`IWDT_F_W2_DATA]};
          end
          `IWDT_OP_JUMP_IND, `IWDT_OP_CALL_IND: begin
            dec_c.source_work_reg = w1[`IWDT_F_IND_REG];
          end
          `IWDT_OP_TBL_RD, `IWDT_OP_TBL_WR: begin
            // RULE17 table access mode
            dec_c.table_mode = w1[`IWDT_F_TBL_MODE];
            dec_c.source_work_reg = whi_reg;
            dec_c.src_mode = whi_mode;
            dec_c.dest_work_reg = wlo_reg;
            dec_c.dst_mode = wlo_mode;
          end
          `IWDT_OP_MOVE_LONG: begin
            // RULE14 literal into file register
            dec_c.cat = IWDT_CAT_LIT;
            dec_c.lit_is_move = 1'b1;
            dec_c.dest_is_file = 1'b1;
            dec_c.file_addr = w1[`IWDT_F_FILE_ADDR];
            dec_c.literal = w2[`IWDT_F_W2_DATA];
            dec_c.prog_addr = '0;
          end
          `IWDT_OP_MOVE_DBL: begin
            dec_c.cat = IWDT_CAT_WORD;
            dec_c.source_work_reg = whi_reg;
            dec_c.src_mode = whi_mode;
            dec_c.dest_work_reg = wlo_reg;
            dec_c.dst_mode = wlo_mode;
            dec_c.prog_addr = '0;
          end
          default: dec_c.cat = IWDT_CAT_CTRL;
        endcase
      end
      `IWDT_GRP_WORD0, `IWDT_GRP_WORD1: begin
        // RULE10 base, source and destination
        dec_c.cat = IWDT_CAT_WORD;
        dec_c.byte_mode = opc[`IWDT_F_WBYTE];
        dec_c.source_work_reg = whi_reg;
        dec_c.src_mode = whi_mode;
        dec_c.dest_work_reg = wlo_reg;
        dec_c.dst_mode = wlo_mode;
      end
      `IWDT_GRP_FILE: begin
        // RULE11 file or register zero
        // RULE18 register zero default
        dec_c.cat = IWDT_CAT_FILE;
        dec_c.byte_mode = w1[`IWDT_F_FILE_BYTE];
        dec_c.file_addr = w1[`IWDT_F_FILE_ADDR];
        dec_c.dest_is_file = w1[`IWDT_F_FILE_DEST];
        dec_c.dest_work_reg = `IWDT_WORK_REG_ZERO_DEFAULT_ZERO;
        dec_c.base_work_reg = `IWDT_WORK_REG_ZERO_DEFAULT_ZERO;
      end
      `IWDT_GRP_BIT: begin
        // RULE12 bit from literal or register
        dec_c.cat = IWDT_CAT_BIT;
        dec_c.bit_target_file = w1[`IWDT_F_BIT_TGT_FILE];
        dec_c.bit_from_reg = w1[`IWDT_F_BIT_FROM_REG];
        dec_c.bit_pos = w1[`IWDT_F_BIT_SEL];
        dec_c.base_work_reg = w1[`IWDT_F_BIT_SEL];
        dec_c.file_addr = 13'(w1[`IWDT_F_BIT_FADDR]);
        dec_c.source_work_reg = wlo_reg;
        dec_c.src_mode = wlo_mode;
      end
      `IWDT_GRP_LIT_ALU: begin
        // RULE13 destination only when separate
        dec_c.cat = IWDT_CAT_LIT;
        dec_c.literal = 16'(w1[`IWDT_F_LIT_ALU]);
        dec_c.dest_work_reg = w1[`IWDT_F_LIT_SEPDST] ? wlo_reg : w1[`IWDT_F_BASE];
        dec_c.dst_mode = w1[`IWDT_F_LIT_SEPDST] ? wlo_mode : IWDT_AM_DIRECT;
      end
      `IWDT_GRP_LIT_MOV: begin
        // RULE14 literal and target
        dec_c.cat = IWDT_CAT_LIT;
        dec_c.lit_is_move = 1'b1;
        dec_c.base_work_reg = '0;
        if (opc == `IWDT_OP_LIT_TO_F) begin
          dec_c.dest_is_file = 1'b1;
          dec_c.literal = 16'(w1[`IWDT_F_LMF_LIT]);
          dec_c.file_addr = 13'(w1[`IWDT_F_LMF_ADDR]);
        end else if (opc == `IWDT_OP_LIT_TO_W) begin
          dec_c.literal = 16'(w1[`IWDT_F_LMW_LIT]);
          dec_c.dest_work_reg = w1[`IWDT_F_LMW_REG];
        end else begin
          dec_c.cat = IWDT_CAT_ILLEGAL;
        end
      end
      `IWDT_GRP_MAC: begin
        // RULE15 multiply-accumulate operands
        dec_c.cat = IWDT_CAT_MAC;
        dec_c.base_work_reg = '0;
        dec_c.acc_sel = w1[`IWDT_F_MAC_ACC];
        dec_c.mult_pair = w1[`IWDT_F_MAC_PAIR];
        dec_c.x_op = w1[`IWDT_F_MAC_XOP];
        dec_c.x_dst = w1[`IWDT_F_MAC_XDST];
        dec_c.y_op = w1[`IWDT_F_MAC_YOP];
        dec_c.y_dst = w1[`IWDT_F_MAC_YDST];
        dec_c.awb = w1[`IWDT_F_MAC_AWB];
      end
      `IWDT_GRP_DSP: begin
        // RULE16 accumulator, operand and shift
        dec_c.cat = IWDT_CAT_DSP;
        dec_c.base_work_reg = '0;
        dec_c.acc_sel = w1[`IWDT_F_DSP_ACC];
        dec_c.shift_from_reg = w1[`IWDT_F_DSP_SHREG];
        dec_c.shift_count_reg = w1[`IWDT_F_DSP_SHAMT];
        dec_c.literal = 16'(w1[`IWDT_F_DSP_SHAMT]);
        dec_c.source_work_reg = wlo_reg;
        dec_c.src_mode = wlo_mode;
        dec_c.dest_work_reg = wlo_reg;
        dec_c.dst_mode = wlo_mode;
      end
      default: begin
        dec_c.cat = IWDT_CAT_ILLEGAL;
        dec_c.base_work_reg = '0;
      end
    endcase
  end

  // ========================================================================
  // Instruction cycle sequencer
  // Chooses the next state, the bundle to publish and the no-op slots.
  always_comb begin
    state_nxt = state_r;
    w1_nxt = w1_r;
    cnt_nxt = cnt_r;
    dec_nxt = dec_r;
    dec_valid_nxt = 1'b0;
    nop_slot_nxt = 1'b0;
    cycles_nxt = cycles_r;
    case (state_r)
      IWDT_ST_DECODE: begin
        if (take) begin
          if (is_dw_op) begin
            // RULE3 hold first word of pair
            w1_nxt = instr_word;
            state_nxt = IWDT_ST_WORD2;
          end else begin
            dec_nxt = dec_c;
            dec_valid_nxt = 1'b1;
            cycles_nxt = cyc_c;
            if (skip_go) begin
              // RULE8 next word becomes a no-op
              state_nxt = IWDT_ST_SKIP;
            end else if (cyc_c != `IWDT_CYC_ONE) begin
              // RULE6 extra slots run as no-ops
              cnt_nxt = cyc_c - `IWDT_CYC_ONE;
              state_nxt = IWDT_ST_EXTRA;
            end
          end
        end
      end
      IWDT_ST_WORD2: begin
        if (take) begin
          // RULE9 pair completes in two cycles
          dec_nxt = dec_c;
          dec_valid_nxt = 1'b1;
          cycles_nxt = `IWDT_CYC_TWO;
          state_nxt = IWDT_ST_DECODE;
        end
      end
      IWDT_ST_EXTRA: begin
        nop_slot_nxt = 1'b1;
        cnt_nxt = cnt_r - `IWDT_CYC_ONE;
        if (cnt_r == `IWDT_CYC_ONE) begin
          state_nxt = IWDT_ST_DECODE;
        end
      end
      IWDT_ST_SKIP, IWDT_ST_SKIP2: begin
        if (take) begin
          // RULE8 skipped pair costs a third cycle
          nop_slot_nxt = 1'b1;
          state_nxt = (state_r == IWDT_ST_SKIP && is_dw_op) ? IWDT_ST_SKIP2 : IWDT_ST_DECODE;
        end
      end
      default: begin
        state_nxt = IWDT_ST_DECODE;
      end
    endcase
  end

  // Fetch is stalled only while IWDT_ST_EXTRA no-op slots run; skip no-op slots still take words.
  assign fetch_ready_nxt = (state_nxt != IWDT_ST_EXTRA);
  // Sequencer registers.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= IWDT_ST_DECODE;
      w1_r <= '0;
      cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      w1_r <= w1_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Output registers.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dec_r <= '0;
      dec_valid_r <= 1'b0;
      nop_slot_r <= 1'b0;
      fetch_ready_r <= 1'b0;
      cycles_r <= '0;
    end else begin
      dec_r <= dec_nxt;
      dec_valid_r <= dec_valid_nxt;
      nop_slot_r <= nop_slot_nxt;
      fetch_ready_r <= fetch_ready_nxt;
      cycles_r <= cycles_nxt;
    end
  end

  // Outputs come straight from flip-flops.
  assign dec = dec_r;
  assign dec_valid = dec_valid_r;
  assign nop_slot = nop_slot_r;
  assign fetch_ready = fetch_ready_r;
  assign instr_cycles = cycles_r;
endmodule

// file: iwdt_consts.svh
// Constants for the instruction word decode and timing block.
`ifndef IWDT_CONSTS_SVH
`define IWDT_CONSTS_SVH

// ==========================================================================
// Word geometry
`define IWDT_WORD_W 24
`define IWDT_REG_W 4
`define IWDT_AM_W 2
`define IWDT_F_OPC 23:16
`define IWDT_F_GROUP 7:4
`define IWDT_F_WBYTE 0
`define IWDT_WORK_REG_ZERO_DEFAULT_ZERO 4'h0

// ==========================================================================
// Opcode groups, taken from the upper opcode nibble
`define IWDT_GRP_CTRL 4'h0
`define IWDT_GRP_WORD0 4'h1
`define IWDT_GRP_WORD1 4'h2
`define IWDT_GRP_FILE 4'h3
`define IWDT_GRP_BIT 4'h4
`define IWDT_GRP_LIT_ALU 4'h5
`define IWDT_GRP_LIT_MOV 4'h6
`define IWDT_GRP_MAC 4'h8
`define IWDT_GRP_DSP 4'h9

// ==========================================================================
// Control group and literal move opcodes
`define IWDT_OP_NOP 8'h00
`define IWDT_OP_BRANCH 8'h01
`define IWDT_OP_BRANCH_COMP 8'h02
`define IWDT_OP_BRANCH_COND 8'h03
`define IWDT_OP_JUMP_ABS 8'h04
`define IWDT_OP_CALL_ABS 8'h05
`define IWDT_OP_JUMP_IND 8'h06
`define IWDT_OP_CALL_IND 8'h07
`define IWDT_OP_RETURN 8'h08
`define IWDT_OP_INT_RETURN 8'h09
`define IWDT_OP_TBL_RD 8'h0A
`define IWDT_OP_TBL_WR 8'h0B
`define IWDT_OP_SKIP_BIT 8'h0C
`define IWDT_OP_SKIP_CMP 8'h0D
`define IWDT_OP_MOVE_LONG 8'h0E
`define IWDT_OP_MOVE_DBL 8'h0F
`define IWDT_OP_LIT_TO_W 8'h60
`define IWDT_OP_LIT_TO_F 8'h61

// ==========================================================================
// Operand field positions
`define IWDT_F_BASE 15:12
`define IWDT_F_WLO_LSB 0
`define IWDT_F_WHI_LSB 6
`define IWDT_F_FILE_ADDR 12:0
`define IWDT_F_FILE_DEST 13
`define IWDT_F_FILE_BYTE 14
`define IWDT_F_BIT_TGT_FILE 15
`define IWDT_F_BIT_FROM_REG 14
`define IWDT_F_BIT_SEL 13:10
`define IWDT_F_BIT_FADDR 9:0
`define IWDT_F_LIT_ALU 11:7
`define IWDT_F_LIT_SEPDST 6
`define IWDT_F_LMW_LIT 15:4
`define IWDT_F_LMW_REG 3:0
`define IWDT_F_LMF_LIT 15:8
`define IWDT_F_LMF_ADDR 7:0
`define IWDT_F_MAC_ACC 15
`define IWDT_F_MAC_PAIR 14:12
`define IWDT_F_MAC_XOP 11:9
`define IWDT_F_MAC_XDST 8:7
`define IWDT_F_MAC_YOP 6:4
`define IWDT_F_MAC_YDST 3:2
`define IWDT_F_MAC_AWB 1:0
`define IWDT_F_DSP_ACC 15
`define IWDT_F_DSP_SHREG 14
`define IWDT_F_DSP_SHAMT 13:10
`define IWDT_F_TBL_MODE 15:14
`define IWDT_F_IND_REG 3:0
`define IWDT_F_PADDR 15:0
`define IWDT_F_DW_ADDR_HI 6:0
`define IWDT_F_W2_DATA 15:0

// ==========================================================================
// Instruction cycle counts
`define IWDT_CYC_ONE 2'h1
`define IWDT_CYC_TWO 2'h2
`define IWDT_CYC_THREE 2'h3

`endif

// file: iwdt_pkg.sv
// Types shared by the instruction word decode and timing block.
package iwdt_pkg;

  // Instruction category presented to the datapath.
  typedef enum logic [3:0] {
    IWDT_CAT_NOP, IWDT_CAT_WORD, IWDT_CAT_FILE, IWDT_CAT_BIT, IWDT_CAT_LIT,
    IWDT_CAT_MAC, IWDT_CAT_DSP, IWDT_CAT_CTRL, IWDT_CAT_ILLEGAL
  } iwdt_cat_t;

  // Working register address modifier.
  typedef enum logic [1:0] {
    IWDT_AM_DIRECT, IWDT_AM_INDIRECT, IWDT_AM_POSTINC, IWDT_AM_PREDEC
  } iwdt_amode_t;

  // Sequencer states.
  typedef enum logic [2:0] {
    IWDT_ST_DECODE, IWDT_ST_WORD2, IWDT_ST_EXTRA, IWDT_ST_SKIP, IWDT_ST_SKIP2
  } iwdt_state_t;

  // Decoded instruction bundle.
  typedef struct packed {
    iwdt_cat_t cat;
    logic [7:0] opcode;
    logic byte_mode;
    logic double_word;
    logic is_nop;
    logic [3:0] base_work_reg;
    logic [3:0] source_work_reg;
    iwdt_amode_t src_mode;
    logic [3:0] dest_work_reg;
    iwdt_amode_t dst_mode;
    logic [12:0] file_addr;
    logic dest_is_file;
    logic bit_target_file;
    logic [3:0] bit_pos;
    logic bit_from_reg;
    logic lit_is_move;
    logic [15:0] literal;
    logic acc_sel;
    logic [2:0] mult_pair;
    logic [2:0] x_op;
    logic [1:0] x_dst;
    logic [2:0] y_op;
    logic [1:0] y_dst;
    logic [1:0] awb;
    logic shift_from_reg;
    logic [3:0] shift_count_reg;
    logic [22:0] prog_addr;
    logic [1:0] table_mode;
  } iwdt_dec_t;

endpackage

// file: iwdt_wfield.sv
// Extracts one working register number and its address modifier.
`timescale 1ns/1ps
`include "iwdt_consts.svh"

module iwdt_wfield #(
  parameter int LSB = 0
) (
  // Instruction word.
  input wire logic [`IWDT_WORD_W-1:0] word,
  // Register select and modifier.
  output logic [`IWDT_REG_W-1:0] regnum,
  output iwdt_pkg::iwdt_amode_t mode
);
  import iwdt_pkg::*;

  // Register number sits low, the modifier just above it.
  assign regnum = word[LSB +: `IWDT_REG_W];
  assign mode = iwdt_amode_t'(word[LSB + `IWDT_REG_W +: `IWDT_AM_W]);
endmodule

// file: iwdt_decoder_props.sv
// Concurrent checks on the ports of the instruction word decoder.
`timescale 1ns/1ps
`include "iwdt_consts.svh"

module iwdt_decoder_props (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Fetch side.
  input wire logic [`IWDT_WORD_W-1:0] instr_word,
  input wire logic instr_valid,
  input wire logic fetch_ready,
  // Datapath side.
  input wire logic cond_true,
  input wire iwdt_pkg::iwdt_dec_t dec,
  input wire logic dec_valid,
  input wire logic nop_slot,
  input wire logic [1:0] instr_cycles
);
  import iwdt_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ==========================================================================
  // Cycle counts and operand fields
  // plain single cycle.
  AST_WORD_ONE: assert property (dec_valid && dec.cat == IWDT_CAT_WORD &&
    dec.opcode != `IWDT_OP_MOVE_DBL |-> instr_cycles == `IWDT_CYC_ONE && fetch_ready
    ##1 !nop_slot)
    else $error("word instruction not one cycle");
  AST_RET_THREE: assert property (dec_valid && dec.opcode inside {`IWDT_OP_RETURN,
    `IWDT_OP_INT_RETURN} |-> instr_cycles == `IWDT_CYC_THREE && !fetch_ready
    ##1 nop_slot ##1 nop_slot && fetch_ready) else $error("return timing wrong");
  AST_FIX_TWO: assert property (dec_valid && dec.opcode inside {8'h01, 8'h02, 8'h06,
    8'h07, 8'h0A, 8'h0B, 8'h0F} |-> instr_cycles == `IWDT_CYC_TWO && !fetch_ready
    ##1 nop_slot && fetch_ready) else $error("two cycle timing wrong");
  AST_PAIR_TWO: assert property (dec_valid && dec.opcode inside {8'h04, 8'h05, 8'h0E}
    |-> dec.double_word && instr_cycles == `IWDT_CYC_TWO) else $error("pair wrong");
  AST_ONLY_THREE: assert property (dec_valid && dec.double_word |->
    dec.opcode inside {8'h04, 8'h05, 8'h0E}) else $error("unexpected pair opcode");
  AST_COND_BR: assert property (dec_valid && dec.opcode == `IWDT_OP_BRANCH_COND |->
    (instr_cycles == `IWDT_CYC_TWO) == $past(cond_true)) else $error("cond branch wrong");
  AST_SKIP_TWO: assert property (dec_valid && dec.opcode == `IWDT_OP_SKIP_BIT &&
    $past(cond_true) |-> instr_cycles == `IWDT_CYC_TWO) else $error("skip count wrong");
  AST_LONE_NOP: assert property (dec_valid && dec.opcode == `IWDT_OP_NOP |->
    dec.cat == IWDT_CAT_NOP && dec.is_nop) else $error("lone word not idle");
  AST_W_FIELDS: assert property (dec_valid && dec.cat == IWDT_CAT_WORD |->
    dec.base_work_reg == $past(instr_word[15:12]) && dec.source_work_reg ==
    $past(instr_word[9:6]) && dec.dest_work_reg == $past(instr_word[3:0]))
    else $error("register fields wrong");
  AST_FILE_OPS: assert property (dec_valid && dec.cat == IWDT_CAT_FILE |->
    dec.file_addr == $past(instr_word[12:0]) && dec.dest_is_file == $past(instr_word[13]))
    else $error("file operands wrong");
  AST_MAC_GRP: assert property (dec_valid && dec.opcode[7:4] == `IWDT_GRP_MAC |->
    dec.cat == IWDT_CAT_MAC && dec.acc_sel == $past(instr_word[15])) else $error("mac wrong");

  // Main scenarios reached.
  COV_PAIR: cover property (dec_valid && dec.double_word);
  COV_RET: cover property (dec_valid && instr_cycles == `IWDT_CYC_THREE);
  COV_SKIP: cover property (nop_slot && fetch_ready ##1 nop_slot);
endmodule

bind iwdt_decoder iwdt_decoder_props u_props (.clk(clk), .rst_b(rst_b),
  .instr_word(instr_word), .instr_valid(instr_valid), .fetch_ready(fetch_ready),
  .cond_true(cond_true), .dec(dec), .dec_valid(dec_valid), .nop_slot(nop_slot),
  .instr_cycles(instr_cycles));

// file: iwdt_fetch_model.sv
// Behavioural program memory fetch unit offering queued words to the decoder.
`timescale 1ns/1ps
`include "iwdt_consts.svh"

module iwdt_fetch_model (
  // Clock.
  input wire logic clk,
  // Handshake with the decoder.
  input wire logic fetch_ready,
  output logic [`IWDT_WORD_W-1:0] instr_word,
  output logic instr_valid
);
  // ==========================================================================
  // Word queue
  logic [`IWDT_WORD_W-1:0] word_q[$];
  logic taken;

  // Start idle with a defined word on the bus.
  initial begin
    instr_word = 24'h000000;
    instr_valid = 1'b0;
    taken = 1'b0;
  end

  // Notes the edge at which the decoder accepted the offered word.
  always @(posedge clk) begin
    taken <= instr_valid && fetch_ready;
  end

  // A refused word stays put; an idle bus toggles its word.
  always @(negedge clk) begin
    if (taken) begin
      void'(word_q.pop_front());
    end
    if (word_q.size() > 0) begin
      instr_word = word_q[0];
      instr_valid = 1'b1;
    end else begin
      instr_word = ~instr_word;
      instr_valid = 1'b0;
    end
  end
endmodule

// file: iwdt_decoder_bench.sv
// Self-checking testbench for the instruction word decoder.
`timescale 1ns/1ps
`include "iwdt_consts.svh"

module iwdt_decoder_bench;
  import iwdt_pkg::*;
  logic clk;
  logic rst_b;
  logic cond_true;
  wire [`IWDT_WORD_W-1:0] instr_word;
  wire instr_valid;
  wire fetch_ready;
  wire iwdt_dec_t dec;
  wire dec_valid;
  wire nop_slot;
  wire [1:0] instr_cycles;
  int failures;
  int check_count;
  int dec_cnt;
  int nop_cnt;
  logic [7:0] cop[9] = '{8'h11, 8'h30, 8'h40, 8'h50, 8'h61, 8'h80, 8'h90, 8'h00, 8'h70};
  iwdt_cat_t ccat[9] = '{IWDT_CAT_WORD, IWDT_CAT_FILE, IWDT_CAT_BIT, IWDT_CAT_LIT,
    IWDT_CAT_LIT, IWDT_CAT_MAC, IWDT_CAT_DSP, IWDT_CAT_NOP, IWDT_CAT_ILLEGAL};
  logic [7:0] tops[9] = '{8'h01, 8'h02, 8'h06, 8'h07, 8'h0A, 8'h0B, 8'h0F, 8'h08, 8'h09};

  // ==========================================================================
  // Design, fetch partner and clock
  iwdt_decoder dut (.clk(clk), .rst_b(rst_b), .instr_word(instr_word),
    .instr_valid(instr_valid), .fetch_ready(fetch_ready), .cond_true(cond_true),
    .dec(dec), .dec_valid(dec_valid), .nop_slot(nop_slot), .instr_cycles(instr_cycles));
  iwdt_fetch_model fetch (.clk(clk), .fetch_ready(fetch_ready), .instr_word(instr_word),
    .instr_valid(instr_valid));

  // Free-running 100 ns clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Counts one-cycle pulses in mid-cycle, where they are settled.
  always @(negedge clk) begin
    if (dec_valid === 1'b1) dec_cnt++;
    if (nop_slot === 1'b1) nop_cnt++;
  end

  // Compares one value and reports a mismatch.
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task complete_run;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Waits for the queue to drain, then checks and clears the pulse counts.
  task settle(input int decs, input int nops);
    int n;
    n = 0;
    while (fetch.word_q.size() != 0 && n < 50) begin
      @(negedge clk);
      #1;
      n++;
    end
    if (n == 50) begin
      failures++;
      complete_run();
    end
    repeat (4) @(negedge clk);
    #1;
    chk("decoded pulses", dec_cnt, decs);
    chk("idle pulses", nop_cnt, nops);
    dec_cnt = 0;
    nop_cnt = 0;
  endtask

  // Register operand form with modifiers.
  task t_word;
    fetch.word_q.push_back(24'h10A97F);
    settle(1, 0);
    chk("base", dec.base_work_reg, 4'hA);
    chk("src", dec.source_work_reg, 4'h5);
    chk("src mode", dec.src_mode, IWDT_AM_POSTINC);
    chk("dst", dec.dest_work_reg, 4'hF);
    chk("dst mode", dec.dst_mode, IWDT_AM_PREDEC);
  endtask

  // Every group but IWDT_GRP_WORD1, plus an unused group, one by one, then all back to back.
  task t_cats;
    for (int i = 0; i < 9; i++) begin
      fetch.word_q.push_back({cop[i], 16'h0000});
      settle(1, 0);
      chk("category", dec.cat, ccat[i]);
      if (i == 0) chk("byte", dec.byte_mode, 1'b1);
    end
    for (int i = 0; i < 9; i++) fetch.word_q.push_back({cop[i], 16'h0000});
    settle(9, 0);
  endtask

  // File, bit and literal operand forms.
  task t_forms;
    fetch.word_q.push_back(24'h301FFF);
    settle(1, 0);
    chk("to file", dec.dest_is_file, 1'b0);
    chk("file addr", dec.file_addr, 13'h1FFF);
    fetch.word_q.push_back(24'h40B555);
    settle(1, 0);
    chk("bit tgt", dec.bit_target_file, 1'b1);
    chk("bit pos", dec.bit_pos, 4'hD);
    fetch.word_q.push_back(24'h503F80);
    settle(1, 0);
    chk("lit", dec.literal, 16'h001F);
    chk("lit dst", dec.dest_work_reg, 4'h3);
    fetch.word_q.push_back(24'h503FC5);
    settle(1, 0);
    chk("sep dst", dec.dest_work_reg, 4'h5);
    fetch.word_q.push_back(24'h60ABC7);
    settle(1, 0);
    chk("mov lit", dec.literal, 16'h0ABC);
    chk("mov move", dec.lit_is_move, 1'b1);
  endtask

  // Signal-processing operand forms.
  task t_dsp;
    fetch.word_q.push_back(24'h80D767);
    settle(1, 0);
    chk("pair", dec.mult_pair, 3'h5);
    chk("xop", {dec.x_op, dec.x_dst}, 5'h0E);
    chk("yop", {dec.y_op, dec.y_dst, dec.awb}, 7'h67);
    fetch.word_q.push_back(24'h906400);
    settle(1, 0);
    chk("shift", {dec.acc_sel, dec.shift_from_reg, dec.shift_count_reg}, 6'h19);
  endtask

  // Fixed extra cycles, table mode and conditional branch.
  task t_cycles;
    for (int i = 0; i < 9; i++) begin
      fetch.word_q.push_back({tops[i], 16'hC000});
      settle(1, (i < 7) ? 1 : 2);
      chk("cycles", instr_cycles, (i < 7) ? 2'h2 : 2'h3);
      chk("single", dec.double_word, 1'b0);
    end
    fetch.word_q.push_back(24'h0AC000);
    settle(1, 1);
    chk("table mode", dec.table_mode, 2'h3);
    fetch.word_q.push_back(24'h030000);
    settle(1, 0);
    cond_true = 1'b1;
    fetch.word_q.push_back(24'h030000);
    settle(1, 1);
    cond_true = 1'b0;
  endtask

  // Two-word instructions, a slow second word and a lone second word.
  task t_pair;
    fetch.word_q.push_back(24'h040055);
    settle(0, 0);
    fetch.word_q.push_back(24'h001234);
    settle(1, 0);
    chk("address", dec.prog_addr, 23'h551234);
    chk("pair cyc", instr_cycles, 2'h2);
    for (int i = 0; i < 2; i++) begin
      fetch.word_q.push_back({(i == 0) ? 8'h05 : 8'h0E, 16'h0001});
      fetch.word_q.push_back(24'h00FFFF);
      settle(1, 0);
      chk("pair flag", dec.double_word, 1'b1);
    end
    fetch.word_q.push_back(24'h00ABCD);
    settle(1, 0);
    chk("lone idle", dec.is_nop, 1'b1);
  endtask

  // Skips over one word and over a pair, then a skip not taken.
  task t_skip;
    cond_true = 1'b1;
    fetch.word_q.push_back(24'h0C0000);
    fetch.word_q.push_back(24'h10A97F);
    settle(1, 1);
    chk("skip cyc", instr_cycles, 2'h2);
    fetch.word_q.push_back(24'h0D0000);
    fetch.word_q.push_back(24'h040055);
    fetch.word_q.push_back(24'h001234);
    settle(1, 2);
    cond_true = 1'b0;
    fetch.word_q.push_back(24'h0C0000);
    fetch.word_q.push_back(24'h10A97F);
    settle(2, 0);
  endtask

  // Main sequence.
  initial begin
    rst_b = 1'b0;
    cond_true = 1'b0;
    failures = 0;
    check_count = 0;
    dec_cnt = 0;
    nop_cnt = 0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    #1;
    t_word();
    t_cats();
    t_forms();
    t_dsp();
    t_cycles();
    t_pair();
    t_skip();
    complete_run();
  end
endmodule
